// ===== ndfs_defines.vh
// Register map, field positions, reset values and unmapped-address answer of the non-volatile duty and fail-safe bank
`ifndef NDFS_DEFINES_VH
`define NDFS_DEFINES_VH
// ****************************************
// Register offsets (byte offsets within the bank)
// ****************************************
`define NDFS_OFF_DUTY_CH6 8'hA6
`define NDFS_OFF_DUTY_CH7 8'hA7
`define NDFS_OFF_DUTY_CH8 8'hA8
`define NDFS_OFF_DUTY_CH9 8'hA9
`define NDFS_OFF_DUTY_CH10 8'hAA
`define NDFS_OFF_DUTY_CH11 8'hAB
`define NDFS_OFF_FS0_LOW 8'hC0
`define NDFS_OFF_FS0_HIGH 8'hC1
`define NDFS_OFF_FS1_LOW 8'hC2
`define NDFS_OFF_FS1_HIGH 8'hC3
`define NDFS_OFF_FS_CTRL 8'hD0
`define NDFS_OFF_CH_STATUS_LOW 8'hD1
`define NDFS_OFF_CH_STATUS_HIGH 8'hD2
// ****************************************
// Reset values
// ****************************************
`define NDFS_RST_DUTY 8'hFF
`define NDFS_RST_FS0_LOW 8'h00
`define NDFS_RST_FS0_HIGH 4'h0
`define NDFS_RST_FS1_LOW 8'hFF
`define NDFS_RST_FS1_HIGH 4'hF
`define NDFS_RST_FS_CTRL 2'h0
// ****************************************
// Field positions
// ****************************************
`define NDFS_HIGH_MSB 3
`define NDFS_CTRL_FS0_BIT 0
`define NDFS_CTRL_FS1_BIT 1
// ****************************************
// Bus answer for unmapped addresses
// ****************************************
`define NDFS_UNMAPPED_DATA 8'h00
`endif

// ===== ndfs_byte_reg.v
// One byte-wide read/write register with a load strobe and a reset value
`timescale 1ns/1ps
`default_nettype none
module ndfs_byte_reg
#(
    parameter [7:0] RESET_VALUE = 8'h00,
    parameter [7:0] WRITE_MASK = 8'hFF
)
(
    input wire clk_i,
    input wire rst_i,
    input wire load_i,
    input wire [7:0] data_i,
    output reg [7:0] value_o
);
    // ****************************************
    // Storage
    // ****************************************
    // Bits outside the mask are forced to zero so reserved bits stay read-as-zero
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            value_o <= RESET_VALUE & WRITE_MASK;
        end
        else if (load_i)
        begin
            value_o <= data_i & WRITE_MASK;
        end
    end
endmodule // ndfs_byte_reg
`default_nettype wire

// ===== ndfs_chan_select.v
// Per-channel output switch driven by the active fail-safe state and its enable bits
`timescale 1ns/1ps
`default_nettype none
module ndfs_chan_select
(
    input wire clk_i,
    input wire rst_i,
    input wire normal_on_i,
    input wire safe0_en_i,
    input wire safe1_en_i,
    input wire in_safe0_i,
    input wire in_safe1_i,
    output reg out_on_o
);
    // ****************************************
    // Output switch
    // ****************************************
    // State 1 takes priority if both are requested; registered to keep the output glitch free
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            out_on_o <= 1'b0;
        end
        else if (in_safe1_i)
        begin
            out_on_o <= safe1_en_i;
        end
        else if (in_safe0_i)
        begin
            out_on_o <= safe0_en_i;
        end
        else
        begin
            out_on_o <= normal_on_i;
        end
    end
endmodule // ndfs_chan_select
`default_nettype wire

// ===== ndfs_regs.v
// Non-volatile duty and fail-safe enable register bank with a classic Wishbone slave
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "ndfs_defines.vh"
// Functional notes
// - Channels 6-11 duty bytes, read/write, reset FFh
// - Fail-safe 0 enables ch0-7, bit=channel, reset clear
// - Fail-safe 0 ch8-11 in bits 3:0, upper zero
// - Fail-safe 1 enables ch0-7, reset all set
// - Fail-safe 1 ch8-11 bits 3:0, reset 0Fh
// - Zero disables channel, one enables it
module ndfs_regs
(
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [7:0] wb_dat_i,
    input wire wb_sel_i,
    output reg [7:0] wb_dat_o,
    output reg wb_ack_o,
    input wire fs_enter0_i,
    input wire fs_enter1_i,
    input wire [11:0] normal_on_i,
    output reg [7:0] stored_duty_ch6_o,
    output reg [7:0] stored_duty_ch7_o,
    output reg [7:0] stored_duty_ch8_o,
    output reg [7:0] stored_duty_ch9_o,
    output reg [7:0] stored_duty_ch10_o,
    output reg [7:0] stored_duty_ch11_o,
    output wire [11:0] chan_on_o,
    output reg [1:0] fs_active_o
);
    // ****************************************
    // Overview
    // ****************************************
    // Ten byte registers sit behind a classic Wishbone slave:
    // six stored duty bytes for channels 6 to 11 and four fail-safe
    // enable bytes, two for each fail-safe state.
    // A control byte lets software force a fail-safe state, and two
    // read-only status bytes show the channel outputs and active states.
    // Every access is answered one cycle after it is taken, so a master
    // that holds its request sees ack in the second cycle.
    // Writes land on the edge that raises ack; reads are latched on it.
    // Reserved upper nibbles of the high enable bytes are never stored,
    // which keeps them reading as zero whatever software writes.
    // The fail-safe request pins are asynchronous and pass two flops first;
    // this costs latency but keeps metastability away from the logic.
    // Channel outputs are registered, so they follow the state one cycle
    // later and cannot glitch while the enables or the state change.
    // Limitation: the stored values are plain flops here; programming of
    // the non-volatile array itself happens outside this block.
    // Unmapped addresses are answered like mapped ones, so a stray access
    // never stalls the bus.

    // ****************************************
    // Synchronisers for the fail-safe requests
    // ****************************************
    reg [1:0] fs_req_meta; // First stage, read only by the second
    reg [1:0] fs_req_sync; // Second stage, safe to use
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // No request is seen while reset is high
            fs_req_meta <= 2'h0;
            fs_req_sync <= 2'h0;
        end
        else
        begin
            // Bit 1 carries state 1, bit 0 state 0
            fs_req_meta <= {fs_enter1_i, fs_enter0_i};
            fs_req_sync <= fs_req_meta;
        end
    end

    // ****************************************
    // Bus decode
    // ****************************************
    wire bus_req; // A request is on the bus this cycle
    wire wr_req; // Write that takes effect now
    // Ack high masks the answer cycle, so a held request is taken once
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // A write with its byte lane low is answered but stores nothing
    assign wr_req = bus_req & wb_we_i & wb_sel_i;

    // Load strobes, one per storage register
    // Unmapped and read-only addresses match none, so such writes are dropped
    // Stored duty bytes
    wire ld_duty6 = wr_req & (wb_adr_i == `NDFS_OFF_DUTY_CH6);
    wire ld_duty7 = wr_req & (wb_adr_i == `NDFS_OFF_DUTY_CH7);
    wire ld_duty8 = wr_req & (wb_adr_i == `NDFS_OFF_DUTY_CH8);
    wire ld_duty9 = wr_req & (wb_adr_i == `NDFS_OFF_DUTY_CH9);
    wire ld_duty10 = wr_req & (wb_adr_i == `NDFS_OFF_DUTY_CH10);
    wire ld_duty11 = wr_req & (wb_adr_i == `NDFS_OFF_DUTY_CH11);
    // Fail-safe enable bytes
    wire ld_fs0_low = wr_req & (wb_adr_i == `NDFS_OFF_FS0_LOW);
    wire ld_fs0_high = wr_req & (wb_adr_i == `NDFS_OFF_FS0_HIGH);
    wire ld_fs1_low = wr_req & (wb_adr_i == `NDFS_OFF_FS1_LOW);
    wire ld_fs1_high = wr_req & (wb_adr_i == `NDFS_OFF_FS1_HIGH);
    // Software force of the fail-safe states
    wire ld_ctrl = wr_req & (wb_adr_i == `NDFS_OFF_FS_CTRL);

    // ****************************************
    // Storage registers
    // ****************************************
    // Outputs of the storage flops, read by the mux, the duty output copies and the channel switches
    wire [7:0] duty6; // Stored duty, channel 6
    wire [7:0] duty7; // Stored duty, channel 7
    wire [7:0] duty8; // Stored duty, channel 8
    wire [7:0] duty9; // Stored duty, channel 9
    wire [7:0] duty10; // Stored duty, channel 10
    wire [7:0] duty11; // Stored duty, channel 11
    wire [7:0] fs0_low; // Fail-safe 0 enables, channels 0-7
    wire [7:0] fs0_high; // Fail-safe 0 enables, channels 8-11
    wire [7:0] fs1_low; // Fail-safe 1 enables, channels 0-7
    wire [7:0] fs1_high; // Fail-safe 1 enables, channels 8-11

    // Full-byte duty values
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_DUTY), .WRITE_MASK(8'hFF)) u_duty6
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_duty6),
        .data_i(wb_dat_i),
        .value_o(duty6)
    );
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_DUTY), .WRITE_MASK(8'hFF)) u_duty7
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_duty7),
        .data_i(wb_dat_i),
        .value_o(duty7)
    );
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_DUTY), .WRITE_MASK(8'hFF)) u_duty8
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_duty8),
        .data_i(wb_dat_i),
        .value_o(duty8)
    );
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_DUTY), .WRITE_MASK(8'hFF)) u_duty9
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_duty9),
        .data_i(wb_dat_i),
        .value_o(duty9)
    );
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_DUTY), .WRITE_MASK(8'hFF)) u_duty10
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_duty10),
        .data_i(wb_dat_i),
        .value_o(duty10)
    );
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_DUTY), .WRITE_MASK(8'hFF)) u_duty11
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_duty11),
        .data_i(wb_dat_i),
        .value_o(duty11)
    );

    // Fail-safe enables; the high halves mask off the reserved nibble
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_FS0_LOW), .WRITE_MASK(8'hFF)) u_fs0_low
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_fs0_low),
        .data_i(wb_dat_i),
        .value_o(fs0_low)
    );
    ndfs_byte_reg #(.RESET_VALUE({4'h0, `NDFS_RST_FS0_HIGH}), .WRITE_MASK(8'h0F)) u_fs0_high
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_fs0_high),
        .data_i(wb_dat_i),
        .value_o(fs0_high)
    );
    ndfs_byte_reg #(.RESET_VALUE(`NDFS_RST_FS1_LOW), .WRITE_MASK(8'hFF)) u_fs1_low
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_fs1_low),
        .data_i(wb_dat_i),
        .value_o(fs1_low)
    );
    ndfs_byte_reg #(.RESET_VALUE({4'h0, `NDFS_RST_FS1_HIGH}), .WRITE_MASK(8'h0F)) u_fs1_high
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(ld_fs1_high),
        .data_i(wb_dat_i),
        .value_o(fs1_high)
    );

    // ****************************************
    // Fail-safe state control
    // ****************************************
    // Software may force a state; a synchronised pin request also enters it
    reg [1:0] fs_force; // Software-forced fail-safe states
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // Normal operation after reset
            fs_force <= `NDFS_RST_FS_CTRL;
        end
        else if (ld_ctrl)
        begin
            // Bits above the two state flags are ignored
            fs_force <= wb_dat_i[1:0];
        end
    end

    // Active state flags, also shown to software
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // No state is active while reset is high
            fs_active_o <= 2'h0;
        end
        else
        begin
            // Either source holds the state for as long as it stays high
            fs_active_o <= fs_force | fs_req_sync;
        end
    end

    // ****************************************
    // Channel outputs
    // ****************************************
    // One enable bit per channel: zero keeps the output off, one turns it on
    wire [11:0] safe0_bits = {fs0_high[`NDFS_HIGH_MSB:0], fs0_low};
    wire [11:0] safe1_bits = {fs1_high[`NDFS_HIGH_MSB:0], fs1_low};
    // One switch per channel; state 1 wins when both states are active
    genvar ch;
    generate
        for (ch = 0; ch < 12; ch = ch + 1)
        begin : g_chan
            ndfs_chan_select u_sel
            (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .normal_on_i(normal_on_i[ch]),
                .safe0_en_i(safe0_bits[ch]),
                .safe1_en_i(safe1_bits[ch]),
                .in_safe0_i(fs_active_o[`NDFS_CTRL_FS0_BIT]),
                .in_safe1_i(fs_active_o[`NDFS_CTRL_FS1_BIT]),
                .out_on_o(chan_on_o[ch])
            );
        end
    endgenerate

    // ****************************************
    // Duty value outputs
    // ****************************************
    // Registered copies so every top output comes from a flip-flop
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // Outputs show the reset value at once
            stored_duty_ch6_o <= `NDFS_RST_DUTY;
            stored_duty_ch7_o <= `NDFS_RST_DUTY;
            stored_duty_ch8_o <= `NDFS_RST_DUTY;
            stored_duty_ch9_o <= `NDFS_RST_DUTY;
            stored_duty_ch10_o <= `NDFS_RST_DUTY;
            stored_duty_ch11_o <= `NDFS_RST_DUTY;
        end
        else
        begin
            // One cycle behind the storage registers
            stored_duty_ch6_o <= duty6;
            stored_duty_ch7_o <= duty7;
            stored_duty_ch8_o <= duty8;
            stored_duty_ch9_o <= duty9;
            stored_duty_ch10_o <= duty10;
            stored_duty_ch11_o <= duty11;
        end
    end

    // ****************************************
    // Read mux
    // ****************************************
    reg [7:0] next_rd_data; // Read data chosen by address
    // Decoded every cycle; latched only when a read is taken
    always @*
    begin
        case (wb_adr_i)
            // Stored duty bytes
            `NDFS_OFF_DUTY_CH6: next_rd_data = duty6;
            `NDFS_OFF_DUTY_CH7: next_rd_data = duty7;
            `NDFS_OFF_DUTY_CH8: next_rd_data = duty8;
            `NDFS_OFF_DUTY_CH9: next_rd_data = duty9;
            `NDFS_OFF_DUTY_CH10: next_rd_data = duty10;
            `NDFS_OFF_DUTY_CH11: next_rd_data = duty11;
            // Fail-safe enable bytes; high halves already hold zero above bit 3
            `NDFS_OFF_FS0_LOW: next_rd_data = fs0_low;
            `NDFS_OFF_FS0_HIGH: next_rd_data = fs0_high;
            `NDFS_OFF_FS1_LOW: next_rd_data = fs1_low;
            `NDFS_OFF_FS1_HIGH: next_rd_data = fs1_high;
            // Control byte and read-only status bytes
            `NDFS_OFF_FS_CTRL: next_rd_data = {6'h00, fs_force};
            `NDFS_OFF_CH_STATUS_LOW: next_rd_data = chan_on_o[7:0];
            `NDFS_OFF_CH_STATUS_HIGH: next_rd_data = {fs_active_o, 2'h0, chan_on_o[11:8]};
            // Unmapped addresses still acknowledge and read as zero
            default: next_rd_data = `NDFS_UNMAPPED_DATA;
        endcase
    end

    // ****************************************
    // Bus answer
    // ****************************************
    // Ack one cycle after the request; it drops the next cycle so a held request is not taken twice
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            // No answer pending after reset
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end
        else
        begin
            // Answer every taken request, mapped or not
            wb_ack_o <= bus_req;
            if (bus_req & ~wb_we_i)
            begin
                // Read data is kept until the next read
                wb_dat_o <= next_rd_data;
            end
        end
    end
endmodule // ndfs_regs
`default_nettype wire

// ===== ndfs_regs_sva.sv
// Checker for the fail-safe enable and stored duty register bank ports
`timescale 1ns/1ps
`default_nettype none
module ndfs_regs_chk
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [11:0] normal_on_i,
    input wire logic [7:0] stored_duty_ch6_o,
    input wire logic [7:0] stored_duty_ch11_o,
    input wire logic [11:0] chan_on_o,
    input wire logic [1:0] fs_active_o
);
    // ****************************************
    // Shadow of the fail-safe enables
    // ****************************************
    logic [11:0] s0; // State 0 enables, ch11..ch0
    logic [11:0] s1; // State 1 enables, ch11..ch0
    logic [7:0] exp_rd; // Expected read byte for C0..C3
    logic take; // Request accepted at this edge
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Load on the same edge as the bank; reserved nibbles are dropped
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s0 <= 12'h000;
            s1 <= 12'hFFF;
        end
        else if (take && wb_we_i && wb_sel_i)
        begin
            case (wb_adr_i)
                8'hC0: s0[7:0] <= wb_dat_i;
                8'hC1: s0[11:8] <= wb_dat_i[3:0];
                8'hC2: s1[7:0] <= wb_dat_i;
                8'hC3: s1[11:8] <= wb_dat_i[3:0];
                default: ;
            endcase
        end
    end
    // Read image of the shadow, upper nibbles read as zero
    always_comb
    begin
        case (wb_adr_i)
            8'hC0: exp_rd = s0[7:0];
            8'hC1: exp_rd = {4'h0, s0[11:8]};
            8'hC2: exp_rd = s1[7:0];
            default: exp_rd = {4'h0, s1[11:8]};
        endcase
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_single: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a single pulse after a request");
    a_duty_reset: assert property ($fell(rst_i) |-> stored_duty_ch6_o == 8'hFF && stored_duty_ch11_o == 8'hFF)
        else $error("stored duty not all ones after reset");
    a_duty_write: assert property (take && wb_we_i && wb_sel_i && wb_adr_i == 8'hAB |->
        ##2 stored_duty_ch11_o == $past(wb_dat_i, 2)) else $error("stored duty ch11 did not take the write");
    a_reserved_zero: assert property (take && !wb_we_i && (wb_adr_i == 8'hC1 || wb_adr_i == 8'hC3) |=>
        wb_dat_o[7:4] == 4'h0) else $error("reserved nibble read nonzero");
    a_read_fs: assert property (take && !wb_we_i && wb_adr_i[7:2] == 6'h30 |=> wb_dat_o == $past(exp_rd))
        else $error("fail-safe enable read mismatch");
    a_fs1_chan: assert property (fs_active_o[1] |=> chan_on_o == $past(s1))
        else $error("channels do not follow state 1 enables");
    a_fs0_chan: assert property (fs_active_o == 2'b01 |=> chan_on_o == $past(s0))
        else $error("channels do not follow state 0 enables");
    a_normal_chan: assert property (fs_active_o == 2'b00 |=> chan_on_o == $past(normal_on_i))
        else $error("channels do not follow normal control");
endmodule // ndfs_regs_chk
bind ndfs_regs ndfs_regs_chk i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .normal_on_i(normal_on_i), .stored_duty_ch6_o(stored_duty_ch6_o),
    .stored_duty_ch11_o(stored_duty_ch11_o), .chan_on_o(chan_on_o), .fs_active_o(fs_active_o));
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the fail-safe enable and stored duty register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i;
    logic rst_i;
    logic cyc, stb, we, sel, fs0, fs1; // Bus request and fail-safe pins
    logic [7:0] adr, dat, rd; // Address, write data, last read byte
    logic [11:0] nrm; // Normal channel control
    wire [7:0] dat_o;
    wire ack;
    wire [7:0] duty [0:5]; // Stored duty outputs ch6..ch11
    wire [11:0] chan;
    wire [1:0] act; // Active fail-safe states
    logic [7:0] mdl [0:9]; // Expected contents: duties, then C0..C3
    int fails;
    int checks;
    int i;
    ndfs_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fs_enter0_i(fs0), .fs_enter1_i(fs1), .normal_on_i(nrm), .stored_duty_ch6_o(duty[0]),
        .stored_duty_ch7_o(duty[1]), .stored_duty_ch8_o(duty[2]), .stored_duty_ch9_o(duty[3]),
        .stored_duty_ch10_o(duty[4]), .stored_duty_ch11_o(duty[5]), .chan_on_o(chan), .fs_active_o(act));
    // ****************************************
    // Expectation helpers
    // ****************************************
    function automatic [7:0] addr_of(input int k);
        addr_of = (k < 6) ? 8'hA6 + 8'(k) : 8'hC0 + 8'(k - 6);
    endfunction
    // Reset image: duties all ones, state 0 clear, state 1 set
    function automatic [7:0] rst_of(input int k);
        rst_of = (k < 6 || k == 8) ? 8'hFF : (k == 9) ? 8'h0F : 8'h00;
    endfunction
    // Only the low nibble of C1 and C3 is storage
    function automatic [7:0] mask_of(input int k);
        mask_of = (k == 7 || k == 9) ? 8'h0F : 8'hFF;
    endfunction
    function automatic [11:0] fs_exp(input int st);
        fs_exp = st ? {mdl[9][3:0], mdl[8]} : {mdl[7][3:0], mdl[6]};
    endfunction
    // ****************************************
    // Drivers and compare
    // ****************************************
    task chk(input [15:0] seen, input [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic cycle; ack is sampled at the edge, so values are pre-update
    // The request waits for ack as long as it takes; only the watchdog ends a hang
    task bus(input [7:0] a, input w, input [7:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task wr(input int k, input [7:0] d);
        bus(addr_of(k), 1'b1, d);
        mdl[k] = d & mask_of(k);
    endtask
    task rdall;
        for (int k = 0; k < 10; k++)
        begin
            bus(addr_of(k), 1'b0, 8'h00);
            chk(16'(rd), 16'(mdl[k]));
        end
    endtask
    task summarize;
        if (fails == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****************************************
    // Clock, watchdog and sequence
    // ****************************************
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Whole run is under a thousand cycles; this is ample headroom
    initial
    begin
        repeat (20000) @(posedge clk_i);
        fails++;
        summarize;
    end
    initial
    begin
        {cyc, stb, we, fs0, fs1} = 5'h00;
        sel = 1'b1;
        adr = 8'h00;
        dat = 8'h00;
        nrm = 12'h000;
        rst_i = 1'b1;
        fails = 0;
        checks = 0;
        void'($urandom(32'hDAE1));
        for (i = 0; i < 10; i++)
            mdl[i] = rst_of(i);
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdall;
        bus(8'h50, 1'b0, 8'h00);
        chk(16'(rd), 16'h0000);
        // A write with its byte lane low is answered but stores nothing
        sel <= 1'b0;
        bus(addr_of(0), 1'b1, 8'h5A);
        sel <= 1'b1;
        bus(addr_of(0), 1'b0, 8'h00);
        chk(16'(rd), 16'(mdl[0]));
        // All-ones corner hits the reserved nibbles, then random contents
        for (i = 0; i < 10; i++)
            wr(i, 8'hFF);
        rdall;
        repeat (4)
        begin
            for (i = 0; i < 10; i++)
                wr(i, 8'($urandom));
            rdall;
            for (i = 0; i < 6; i++)
                chk(16'(duty[i]), 16'(mdl[i]));
            nrm <= 12'($urandom);
            fs0 <= 1'b1;
            repeat (6) @(posedge clk_i);
            chk(16'(chan), 16'(fs_exp(0)));
            chk(16'(act), 16'h0001);
            fs1 <= 1'b1;
            repeat (6) @(posedge clk_i);
            chk(16'(chan), 16'(fs_exp(1)));
            chk(16'(act), 16'h0003);
            {fs0, fs1} <= 2'b00;
            repeat (6) @(posedge clk_i);
            chk(16'(chan), 16'(nrm));
            chk(16'(act), 16'h0000);
        end
        // Software force: state 0, then both with state 1 winning, then released
        bus(8'hD0, 1'b1, 8'h01);
        repeat (3) @(posedge clk_i);
        chk(16'(chan), 16'(fs_exp(0)));
        chk(16'(act), 16'h0001);
        bus(8'hD1, 1'b0, 8'h00);
        chk(16'(rd), 16'(mdl[6]));
        bus(8'hD2, 1'b0, 8'h00);
        chk(16'(rd), {8'h00, 4'h4, mdl[7][3:0]});
        bus(8'hD0, 1'b1, 8'h03);
        repeat (3) @(posedge clk_i);
        chk(16'(chan), 16'(fs_exp(1)));
        chk(16'(act), 16'h0003);
        bus(8'hD0, 1'b0, 8'h00);
        chk(16'(rd), 16'h0003);
        bus(8'hD0, 1'b1, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(16'(chan), 16'(nrm));
        chk(16'(act), 16'h0000);
        // Reset in mid-run restores every default
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 10; i++)
            mdl[i] = rst_of(i);
        rdall;
        summarize;
    end
endmodule // tb_top
`default_nettype wire
